//--- rtl/icp_io_channel_processor.sv
// I/O channel processor: device bus sequencer, data channel, interrupts.
// Assumes processor and memory bus share sys_clk; device lines are async.
//
// Behaviour
// - Skip request sets cpu_skip when addressed device flag is asserted.
// - Accumulator words of 18 bits go out to or come in from devices.
// - Status read gathers 18 device status bits into the accumulator.
// - Block count and address live in two memory words per device.
// - Block transfers move words to or from consecutive memory addresses.
// - Program interrupt taken only at instruction completion.
// - Eight priority levels: four hardware, four software.
// - Priority levels nest; debreak releases the highest active level.
// - Add-to-memory writes sum back and returns it to the device.
// - Increment request adds one to device-named memory word.
// - Channel device data is captured in an 18-bit input buffer first.
// - Every adder result lands in the data storage register.
// - Add cycle feeds memory word and input buffer to the adder.
// - Requests are synchronised, granted by priority, then sequenced.
// - Device commands are delivered to the addressed device.
// - Channel arithmetic uses its own adder; its memory cycles withhold cpu_mem_grant.
// - Channel wins memory over the CPU on simultaneous requests.
`timescale 1ns/10ps
module icp_io_channel_processor
	import icp_pkg::*;
#(
	parameter int DEV_W = DEV_ADDR_W
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic cpu_req,
	input wire logic [2:0] cpu_op,
	input wire logic [DEV_W-1:0] cpu_dev,
	input wire logic [17:0] cpu_ac_out,
	output logic cpu_done,
	output logic [17:0] cpu_ac_in,
	output logic cpu_skip,
	input wire logic cpu_mem_req,
	output logic cpu_mem_grant,
	input wire logic cpu_instr_end,
	input wire logic prog_int_en,
	input wire logic [3:0] sw_vec_req,
	input wire logic cpu_debreak,
	output logic prog_int_take,
	output logic vec_take,
	output logic [2:0] vec_level,
	output logic [17:0] vec_entry,
	output logic [DEV_W-1:0] dev_sel,
	output logic [2:0] dev_io_func,
	output logic dev_io_strobe,
	output logic [17:0] dev_data_out,
	input wire logic [17:0] dev_data_in,
	input wire logic [17:0] dev_status,
	input wire logic dev_flag,
	input wire logic dev_chan_req,
	input wire logic [2:0] dev_chan_op,
	input wire logic [DEV_W-1:0] dev_chan_id,
	input wire logic [17:0] dev_addr_in,
	output logic dev_chan_grant,
	output logic dev_block_done,
	input wire logic dev_prog_req,
	input wire logic [3:0] dev_vec_req,
	input wire logic [17:0] dev_vec_addr,
	output logic [3:0] dev_vec_grant,
	output logic mem_req,
	output logic mem_we,
	output logic [17:0] mem_addr,
	output logic [17:0] mem_wdata,
	input wire logic [17:0] mem_rdata,
	input wire logic mem_ack
);

	// Plain 18-bit adder
	function automatic logic [17:0] icp_add(input logic [17:0] a,
		input logic [17:0] b);
		icp_add = a + b;
	endfunction

	// Lowest set index of an 8-bit mask, with a valid bit on top
	function automatic logic [3:0] icp_prio(input logic [7:0] v);
		icp_prio = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				icp_prio = {1'b1, 3'(i)};
			end
		end
	endfunction

	// Pin synchroniser: three stages, a change counts when 2 and 3 agree
	logic [6:0] pin_raw, pin_s1, pin_s2, pin_s3, pin_f, next_pin_f;
	assign pin_raw = {dev_chan_req, dev_prog_req, dev_vec_req, dev_flag};
	assign next_pin_f = (~(pin_s2 ^ pin_s3) & pin_s3) |
		((pin_s2 ^ pin_s3) & pin_f);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1 <= 7'h00;
			pin_s2 <= 7'h00;
			pin_s3 <= 7'h00;
			pin_f <= 7'h00;
		end else if (clk_en) begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= next_pin_f;
		end
	end

	logic chan_req_f, prog_req_f, flag_f;
	logic [3:0] vec_hw_f;
	assign chan_req_f = pin_f[6];
	assign prog_req_f = pin_f[5];
	assign vec_hw_f = pin_f[4:1];
	assign flag_f = pin_f[0];

	// Sequencer and data path state
	icp_state_t state, next_state;
	icp_chan_op_t op, next_op;
	logic [17:0] io_buf, next_io_buf, dsr, next_dsr;
	logic [17:0] next_mem_addr, next_cpu_ac_in;
	logic [17:0] adder_a, adder_b, sum, wc_addr;
	logic [DEV_W-1:0] next_dev_sel;
	logic [2:0] next_dev_io_func;
	logic [3:0] io_cnt, next_io_cnt;
	logic ovf, next_ovf, chan_wait, next_chan_wait, is_mc, chan_go;
	logic next_cpu_done, next_cpu_skip, next_mem_req, next_mem_we;
	logic next_chan_grant, next_block_done, next_cpu_mem_grant;

	assign is_mc = (op == CH_MC_IN) || (op == CH_MC_OUT) || (op == CH_ADD);
	assign wc_addr = icp_add(MC_TABLE_BASE, 18'({dev_sel, 1'b0}));
	assign chan_go = chan_req_f && !chan_wait;
	assign sum = icp_add(adder_a, adder_b);
	assign dev_data_out = dsr;
	assign mem_wdata = dsr;

	// Mixer: steer operands onto the adder inputs for each step
	always_comb begin
		adder_a = io_buf;
		adder_b = WORD_RST;
		case (state)
			ST_IDLE: adder_a = cpu_ac_out;
			ST_WC_RD, ST_CA_RD: begin
				adder_a = mem_rdata;
				adder_b = ADD_ONE;
			end
			ST_DAT_RD: begin
				adder_a = mem_rdata;
				if (op == CH_ADD) begin
					adder_b = io_buf;
				end else if (op == CH_INCR) begin
					adder_b = ADD_ONE;
				end
			end
			default: adder_a = io_buf;
		endcase
	end

	// Sequencer next values
	always_comb begin
		next_state = state;
		next_op = op;
		next_io_buf = io_buf;
		next_dsr = dsr;
		next_mem_addr = mem_addr;
		next_dev_sel = dev_sel;
		next_dev_io_func = dev_io_func;
		next_io_cnt = io_cnt;
		next_ovf = ovf;
		next_cpu_ac_in = cpu_ac_in;
		next_cpu_skip = cpu_skip;
		next_chan_wait = chan_wait && chan_req_f;
		case (state)
			ST_IDLE: begin
				if (chan_go) begin
					next_io_buf = dev_data_in;
					next_op = icp_chan_op_t'(dev_chan_op);
					next_dev_sel = dev_chan_id;
					next_mem_addr = dev_addr_in;
					next_ovf = 1'b0;
					next_state = ST_SETUP;
				end else if (cpu_req) begin
					next_dev_sel = cpu_dev;
					next_dev_io_func = cpu_op;
					next_dsr = sum;
					next_cpu_skip = 1'b0;
					next_io_cnt = 4'(IO_SETTLE_CYC - 1);
					next_state = ST_IO_WAIT;
				end
			end
			ST_SETUP: begin
				if (is_mc) begin
					next_mem_addr = wc_addr;
					next_state = ST_WC_RD;
				end else if (op == CH_SC_IN) begin
					next_dsr = sum;
					next_state = ST_DAT_WR;
				end else begin
					next_state = ST_DAT_RD;
				end
			end
			ST_WC_RD: if (mem_ack) begin
				next_dsr = sum;
				next_ovf = (sum == WORD_RST);
				next_state = ST_WC_WR;
			end
			ST_WC_WR: if (mem_ack) begin
				next_mem_addr = wc_addr | MC_CA_OFFSET;
				next_state = ST_CA_RD;
			end
			ST_CA_RD: if (mem_ack) begin
				next_dsr = sum;
				next_state = ST_CA_WR;
			end
			ST_CA_WR: if (mem_ack) begin
				next_mem_addr = dsr;
				if (op == CH_MC_IN) begin
					next_dsr = sum;
					next_state = ST_DAT_WR;
				end else begin
					next_state = ST_DAT_RD;
				end
			end
			ST_DAT_RD: if (mem_ack) begin
				next_dsr = sum;
				if (op == CH_MC_OUT || op == CH_SC_OUT) begin
					next_state = ST_FINISH;
				end else begin
					next_state = ST_DAT_WR;
				end
			end
			ST_DAT_WR: if (mem_ack) begin
				next_state = ST_FINISH;
			end
			ST_FINISH: begin
				next_chan_wait = 1'b1;
				next_state = ST_IDLE;
			end
			ST_IO_WAIT: begin
				if (io_cnt == 4'h0) begin
					if (dev_io_func == CPU_AC_IN) begin
						next_cpu_ac_in = dev_data_in;
					end else if (dev_io_func == CPU_STATUS) begin
						next_cpu_ac_in = dev_status;
					end else if (dev_io_func == CPU_SKIP) begin
						next_cpu_skip = flag_f;
					end
					next_state = ST_IO_DONE;
				end else begin
					next_io_cnt = io_cnt - 4'h1;
				end
			end
			ST_IO_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
		next_mem_req = (next_state inside {ST_WC_RD, ST_WC_WR, ST_CA_RD,
			ST_CA_WR, ST_DAT_RD, ST_DAT_WR});
		next_mem_we = (next_state inside {ST_WC_WR, ST_CA_WR, ST_DAT_WR});
		next_cpu_mem_grant = cpu_mem_req && !next_mem_req;
		next_cpu_done = (next_state == ST_IO_DONE);
		next_chan_grant = (next_state == ST_FINISH);
		next_block_done = (next_state == ST_FINISH) && next_ovf && is_mc;
	end

	// Sequencer registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			op <= CH_MC_IN;
			io_buf <= WORD_RST;
			dsr <= WORD_RST;
			mem_addr <= WORD_RST;
			dev_sel <= '0;
			dev_io_func <= 3'h0;
			io_cnt <= 4'h0;
			ovf <= 1'b0;
			chan_wait <= 1'b0;
			cpu_ac_in <= WORD_RST;
			cpu_skip <= 1'b0;
			cpu_done <= 1'b0;
			cpu_mem_grant <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			dev_io_strobe <= 1'b0;
			dev_chan_grant <= 1'b0;
			dev_block_done <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			op <= next_op;
			io_buf <= next_io_buf;
			dsr <= next_dsr;
			mem_addr <= next_mem_addr;
			dev_sel <= next_dev_sel;
			dev_io_func <= next_dev_io_func;
			io_cnt <= next_io_cnt;
			ovf <= next_ovf;
			chan_wait <= next_chan_wait;
			cpu_ac_in <= next_cpu_ac_in;
			cpu_skip <= next_cpu_skip;
			cpu_done <= next_cpu_done;
			cpu_mem_grant <= next_cpu_mem_grant;
			mem_req <= next_mem_req;
			mem_we <= next_mem_we;
			dev_io_strobe <= (next_state == ST_IO_WAIT);
			dev_chan_grant <= next_chan_grant;
			dev_block_done <= next_block_done;
		end
	end

	// Interrupt next values: priority levels and program interrupt
	logic [7:0] active, next_active, act_after;
	logic [3:0] cand, act_top, after_top;
	logic take, next_prog_int_take;
	logic [2:0] next_vec_level;
	logic [17:0] next_vec_entry;
	logic [3:0] next_vec_grant;
	always_comb begin
		cand = icp_prio({sw_vec_req, vec_hw_f});
		act_top = icp_prio(active);
		act_after = active;
		if (cpu_debreak && act_top[3]) begin
			act_after[act_top[2:0]] = 1'b0;
		end
		after_top = icp_prio(act_after);
		take = cpu_instr_end && cand[3] &&
			(!after_top[3] || cand[2:0] < after_top[2:0]);
		next_active = act_after;
		next_vec_level = vec_level;
		next_vec_entry = vec_entry;
		next_vec_grant = 4'h0;
		if (take) begin
			next_active[cand[2:0]] = 1'b1;
			next_vec_level = cand[2:0];
			if (cand[2] == 1'b0) begin
				next_vec_entry = dev_vec_addr;
				next_vec_grant = 4'(4'h1 << cand[1:0]);
			end else begin
				next_vec_entry = icp_add(SW_VECTOR_BASE, 18'(cand[2:0]));
			end
		end
		next_prog_int_take = cpu_instr_end && prog_int_en && prog_req_f &&
			!cand[3] && !after_top[3];
	end

	// Interrupt registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			active <= 8'h00;
			vec_take <= 1'b0;
			vec_level <= 3'h0;
			vec_entry <= WORD_RST;
			dev_vec_grant <= 4'h0;
			prog_int_take <= 1'b0;
		end else if (clk_en) begin
			active <= next_active;
			vec_take <= take;
			vec_level <= next_vec_level;
			vec_entry <= next_vec_entry;
			dev_vec_grant <= next_vec_grant;
			prog_int_take <= next_prog_int_take;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b || !clk_en);

	sequence s_skip_sample;
		state == ST_IO_WAIT && io_cnt == 4'h0 && dev_io_func == CPU_SKIP;
	endsequence
	property p_skip;
		s_skip_sample |=> cpu_skip == $past(flag_f) ##0 cpu_done;
	endproperty
	a_skip: assert property (p_skip) else $error("skip mismatch");

	property p_chan_first;
		state == ST_IDLE && chan_go && cpu_req |=> state == ST_SETUP;
	endproperty
	a_chan_first: assert property (p_chan_first)
		else $error("channel not favoured");

	property p_mem_excl;
		!(mem_req && cpu_mem_grant);
	endproperty
	a_mem_excl: assert property (p_mem_excl)
		else $error("memory granted to both");

	sequence s_wc_read;
		state == ST_WC_RD && mem_ack;
	endsequence
	property p_wc_update;
		s_wc_read |=> state == ST_WC_WR && mem_we &&
			dsr == 18'($past(mem_rdata) + 18'h1);
	endproperty
	a_wc_update: assert property (p_wc_update)
		else $error("word count not advanced");

	property p_ca_use;
		state == ST_CA_WR && mem_ack |=> mem_addr == $past(dsr);
	endproperty
	a_ca_use: assert property (p_ca_use)
		else $error("data address not taken");

	property p_add_sum;
		state == ST_DAT_RD && mem_ack && op == CH_ADD |=>
			dsr == 18'($past(mem_rdata) + io_buf) ##0 mem_we;
	endproperty
	a_add_sum: assert property (p_add_sum)
		else $error("add-to-memory sum wrong");

	property p_incr;
		state == ST_DAT_RD && mem_ack && op == CH_INCR |=>
			dsr == 18'($past(mem_rdata) + 18'h1);
	endproperty
	a_incr: assert property (p_incr) else $error("increment wrong");

	property p_prog_boundary;
		prog_int_take |-> $past(cpu_instr_end) && !vec_take;
	endproperty
	a_prog_boundary: assert property (p_prog_boundary)
		else $error("program interrupt off boundary");

	property p_debreak;
		cpu_debreak && act_top[3] && !take |=>
			$countones(active) == $countones($past(active)) - 1;
	endproperty
	a_debreak: assert property (p_debreak)
		else $error("debreak did not release level");

endmodule

//--- rtl/icp_pkg.sv
// Shared constants and types for the I/O channel processor.
// Assumes an 18-bit word machine with one system clock at 40 MHz.
package icp_pkg;

	// Word and addressing widths
	localparam int WORD_W = 18;
	localparam int DEV_ADDR_W = 8;
	localparam int VEC_LEVELS = 8;
	localparam int VEC_HW_LEVELS = 4;

	// Clock and bus settle timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int IO_SETTLE_NS = 200;
	localparam int IO_SETTLE_CYC = (IO_SETTLE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;

	// Memory words of the block transfer table: word count at even
	// offset, current address at the following odd offset
	localparam logic [17:0] MC_TABLE_BASE = 18'h00010;
	localparam logic [17:0] MC_CA_OFFSET = 18'h00001;
	// Entry point base for software-requested priority levels
	localparam logic [17:0] SW_VECTOR_BASE = 18'h00040;

	// Reset value and increment constant
	localparam logic [17:0] WORD_RST = 18'h00000;
	localparam logic [17:0] ADD_ONE = 18'h00001;

	// Processor requests on the device bus
	typedef enum logic [2:0] {
		CPU_CMD = 3'h0,
		CPU_AC_OUT = 3'h1,
		CPU_AC_IN = 3'h2,
		CPU_STATUS = 3'h3,
		CPU_SKIP = 3'h4
	} icp_cpu_op_t;

	// Device channel requests
	typedef enum logic [2:0] {
		CH_MC_IN = 3'h0,
		CH_MC_OUT = 3'h1,
		CH_ADD = 3'h2,
		CH_INCR = 3'h3,
		CH_SC_IN = 3'h4,
		CH_SC_OUT = 3'h5
	} icp_chan_op_t;

	// Sequencer states, Gray coded in the listed order from ST_IDLE up to ST_FINISH
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SETUP = 4'h1,
		ST_WC_RD = 4'h3,
		ST_WC_WR = 4'h2,
		ST_CA_RD = 4'h6,
		ST_CA_WR = 4'h7,
		ST_DAT_RD = 4'h5,
		ST_DAT_WR = 4'h4,
		ST_FINISH = 4'hc,
		ST_IO_WAIT = 4'h8,
		ST_IO_DONE = 4'h9
	} icp_state_t;

endpackage

//--- verification/icp_dev_model.sv
// Peripheral model: answers device bus reads and raises channel requests.
// Assumes the bench calls its task at falling edges of sys_clk.
`timescale 1ns/10ps
module icp_dev_model
	import icp_pkg::*;
(
	input wire logic sys_clk,
	input wire logic dev_io_strobe,
	input wire logic dev_chan_grant,
	input wire logic dev_block_done,
	input wire logic [17:0] dev_data_out,
	output logic [17:0] dev_data_in,
	output logic [17:0] dev_status,
	output logic dev_flag,
	output logic dev_chan_req,
	output logic [2:0] dev_chan_op,
	output logic [7:0] dev_chan_id,
	output logic [17:0] dev_addr_in,
	output logic dev_prog_req,
	output logic [3:0] dev_vec_req,
	output logic [17:0] dev_vec_addr
);
	logic [17:0] dval, sval, ch_res;
	logic ch_done, ch_seen;

	// Lines not being sampled show the inverse of the held word
	assign dev_data_in = (dev_io_strobe || dev_chan_req) ? dval : ~dval;
	assign dev_status = dev_io_strobe ? sval : ~sval;

	// Idle device: no requests, own entry address held ready
	initial begin
		dval = 18'h00000;
		sval = 18'h00000;
		dev_flag = 1'b0;
		dev_chan_req = 1'b0;
		dev_chan_op = 3'h0;
		dev_chan_id = 8'h00;
		dev_addr_in = 18'h00000;
		dev_prog_req = 1'b0;
		dev_vec_req = 4'h0;
		dev_vec_addr = 18'h0abcd;
	end

	// One channel word; single ops take their address here, not from memory
	task automatic chan(input logic [2:0] op, input logic [7:0] id,
		input logic [17:0] d, input logic [17:0] a);
		int i;
		dev_chan_req = 1'b1;
		dev_chan_op = op;
		dev_chan_id = id;
		dval = d;
		dev_addr_in = a;
		for (i = 0; i < 60 && dev_chan_grant !== 1'b1; i++)
			@(negedge sys_clk);
		ch_seen = dev_chan_grant;
		ch_done = dev_block_done;
		ch_res = dev_data_out;
		dev_chan_req = 1'b0;
		// Request must be seen low before the next one counts
		repeat (6) @(negedge sys_clk);
	endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the I/O channel processor.
// Assumes a one-cycle memory reply and one peripheral model.
`timescale 1ns/10ps
module testbench
	import icp_pkg::*;
;
	logic sys_clk, rst_b, cpu_req, cpu_done, cpu_skip, cpu_mem_grant;
	logic cpu_instr_end, prog_int_en, cpu_debreak, prog_int_take, vec_take;
	logic dev_io_strobe, dev_flag, dev_chan_req, dev_chan_grant;
	logic dev_block_done, dev_prog_req, mem_req, mem_we, mem_ack;
	logic [2:0] cpu_op, vec_level, dev_io_func, dev_chan_op;
	logic [7:0] cpu_dev, dev_sel, dev_chan_id;
	logic [3:0] sw_vec_req, dev_vec_req, dev_vec_grant, grant_or;
	logic [17:0] cpu_ac_out, cpu_ac_in, vec_entry, dev_data_out;
	logic [17:0] dev_data_in, dev_status, dev_addr_in, dev_vec_addr;
	logic [17:0] mem_addr, mem_wdata, mem_rdata, vec;
	logic [17:0] mem [0:255];
	logic seen_prog, seen_vec;
	logic [2:0] lvl;
	int n_fail = 0;
	int comparisons = 0;

	icp_io_channel_processor icp_io_channel_processor_inst (.sys_clk(sys_clk),
		.rst_b(rst_b), .clk_en(1'b1), .cpu_req(cpu_req), .cpu_op(cpu_op),
		.cpu_dev(cpu_dev), .cpu_ac_out(cpu_ac_out), .cpu_done(cpu_done),
		.cpu_ac_in(cpu_ac_in), .cpu_skip(cpu_skip), .cpu_mem_req(1'b1),
		.cpu_mem_grant(cpu_mem_grant), .cpu_instr_end(cpu_instr_end),
		.prog_int_en(prog_int_en), .sw_vec_req(sw_vec_req),
		.cpu_debreak(cpu_debreak), .prog_int_take(prog_int_take),
		.vec_take(vec_take), .vec_level(vec_level), .vec_entry(vec_entry),
		.dev_sel(dev_sel),
		.dev_io_func(dev_io_func), .dev_io_strobe(dev_io_strobe),
		.dev_data_out(dev_data_out), .dev_data_in(dev_data_in),
		.dev_status(dev_status), .dev_flag(dev_flag),
		.dev_chan_req(dev_chan_req), .dev_chan_op(dev_chan_op),
		.dev_chan_id(dev_chan_id), .dev_addr_in(dev_addr_in),
		.dev_chan_grant(dev_chan_grant), .dev_block_done(dev_block_done),
		.dev_prog_req(dev_prog_req), .dev_vec_req(dev_vec_req),
		.dev_vec_addr(dev_vec_addr), .dev_vec_grant(dev_vec_grant),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

	icp_dev_model dev_model_inst (.sys_clk(sys_clk),
		.dev_io_strobe(dev_io_strobe), .dev_chan_grant(dev_chan_grant),
		.dev_block_done(dev_block_done), .dev_data_out(dev_data_out),
		.dev_data_in(dev_data_in), .dev_status(dev_status),
		.dev_flag(dev_flag), .dev_chan_req(dev_chan_req),
		.dev_chan_op(dev_chan_op), .dev_chan_id(dev_chan_id),
		.dev_addr_in(dev_addr_in), .dev_prog_req(dev_prog_req),
		.dev_vec_req(dev_vec_req), .dev_vec_addr(dev_vec_addr));

	task automatic chk(input string nm, input logic [17:0] e,
		input logic [17:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic test_done;
		if (n_fail == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Memory with one-cycle reply; the processor must wait while we serve
	always @(negedge sys_clk) begin
		if (mem_req === 1'b1)
			chk("cpu_mem_grant", 18'h0, {17'h0, cpu_mem_grant});
		if (mem_req === 1'b1 && mem_ack === 1'b0) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr[7:0]];
			if (mem_we === 1'b1)
				mem[mem_addr[7:0]] <= mem_wdata;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end

	// One processor device request, strobe length and done pulse judged
	task automatic cpu_io(input logic [2:0] op, input logic [7:0] dv,
		input logic [17:0] ac);
		int i, n;
		cpu_req = 1'b1;
		cpu_op = op;
		cpu_dev = dv;
		cpu_ac_out = ac;
		n = 0;
		for (i = 0; i < 40 && cpu_done !== 1'b1; i++) begin
			@(negedge sys_clk);
			if (dev_io_strobe === 1'b1)
				n++;
		end
		chk("strobe cycles", 18'(IO_SETTLE_CYC), 18'(n));
		chk("cpu_done", 18'h1, {17'h0, cpu_done});
		cpu_req = 1'b0;
		@(negedge sys_clk);
		chk("cpu_done low", 18'h0, {17'h0, cpu_done});
	endtask

	task automatic t_cmd;
		cpu_io(CPU_CMD, 8'hff, 18'h2a5a5);
		chk("dev_sel", 18'h000ff, {10'h0, dev_sel});
		chk("dev_io_func", {15'h0, CPU_CMD}, {15'h0, dev_io_func});
		chk("dev_data_out", 18'h2a5a5, dev_data_out);
	endtask

	task automatic t_ac;
		cpu_io(CPU_AC_OUT, 8'h03, 18'h3ffff);
		chk("ac out", 18'h3ffff, dev_data_out);
		dev_model_inst.dval = 18'h3c3c3;
		cpu_io(CPU_AC_IN, 8'h03, 18'h00000);
		chk("ac in", 18'h3c3c3, cpu_ac_in);
		dev_model_inst.sval = 18'h20001;
		cpu_io(CPU_STATUS, 8'h00, 18'h00000);
		chk("status", 18'h20001, cpu_ac_in);
	endtask

	task automatic t_skip;
		dev_model_inst.dev_flag = 1'b1;
		repeat (5) @(negedge sys_clk);
		cpu_io(CPU_SKIP, 8'h80, 18'h00000);
		chk("skip set", 18'h1, {17'h0, cpu_skip});
		dev_model_inst.dev_flag = 1'b0;
		repeat (5) @(negedge sys_clk);
		cpu_io(CPU_SKIP, 8'h80, 18'h00000);
		chk("skip clear", 18'h0, {17'h0, cpu_skip});
	endtask

	// Two-word block: table for device 3, count -2, address before 0x80
	task automatic t_block;
		mem[MC_TABLE_BASE[7:0] + 8'd6] = 18'h3fffe;
		mem[MC_TABLE_BASE[7:0] + 8'd7] = 18'h0007f;
		mem[8'h81] = 18'h02222;
		dev_model_inst.chan(CH_MC_IN, 8'h03, 18'h11111, 18'h0);
		chk("word in", 18'h11111, mem[8'h80]);
		chk("count", 18'h3ffff, mem[MC_TABLE_BASE[7:0] + 8'd6]);
		chk("not done", 18'h0, {17'h0, dev_model_inst.ch_done});
		dev_model_inst.chan(CH_MC_OUT, 8'h03, 18'h0, 18'h0);
		chk("word out", 18'h02222, dev_model_inst.ch_res);
		chk("address", 18'h00081, mem[MC_TABLE_BASE[7:0] + 8'd7]);
		chk("done", 18'h1, {17'h0, dev_model_inst.ch_done});
	endtask

	// Add wraps at 18 bits; increment wraps the all-ones word
	task automatic t_arith;
		mem[MC_TABLE_BASE[7:0] + 8'd2] = 18'h3ffff;
		mem[MC_TABLE_BASE[7:0] + 8'd3] = 18'h0009f;
		mem[8'ha0] = 18'h3fffe;
		dev_model_inst.chan(CH_ADD, 8'h01, 18'h00003, 18'h0);
		chk("sum in memory", 18'h00001, mem[8'ha0]);
		chk("sum to device", 18'h00001, dev_model_inst.ch_res);
		mem[8'hc0] = 18'h3ffff;
		dev_model_inst.chan(CH_INCR, 8'h02, 18'h0, 18'h000c0);
		chk("incremented", 18'h00000, mem[8'hc0]);
		chk("incr result", 18'h00000, dev_model_inst.ch_res);
		chk("incr grant", 18'h1, {17'h0, dev_model_inst.ch_seen});
	endtask

	task automatic t_single;
		mem[MC_TABLE_BASE[7:0]] = 18'h12345;
		dev_model_inst.chan(CH_SC_IN, 8'h00, 18'h15555, 18'h000d0);
		chk("single in", 18'h15555, mem[8'hd0]);
		dev_model_inst.chan(CH_SC_OUT, 8'h00, 18'h0, 18'h000d0);
		chk("single out", 18'h15555, dev_model_inst.ch_res);
		chk("table kept", 18'h12345, mem[MC_TABLE_BASE[7:0]]);
	endtask

	// Watch the interrupt outputs for a few cycles; the first look is at
	// once, so a one-cycle take launched by the boundary edge is caught
	task automatic watch(input int n);
		seen_prog = 1'b0;
		seen_vec = 1'b0;
		grant_or = 4'h0;
		repeat (n) begin
			if (prog_int_take === 1'b1)
				seen_prog = 1'b1;
			if (vec_take === 1'b1) begin
				seen_vec = 1'b1;
				lvl = vec_level;
				vec = vec_entry;
			end
			grant_or = grant_or | dev_vec_grant;
			@(negedge sys_clk);
		end
	endtask

	task automatic boundary(input logic dbr);
		cpu_instr_end = 1'b1;
		cpu_debreak = dbr;
		@(negedge sys_clk);
		cpu_instr_end = 1'b0;
		cpu_debreak = 1'b0;
	endtask

	task automatic t_prog;
		dev_model_inst.dev_prog_req = 1'b1;
		prog_int_en = 1'b1;
		watch(8);
		chk("early take", 18'h0, {17'h0, seen_prog});
		boundary(1'b0);
		prog_int_en = 1'b0;
		watch(4);
		chk("take at end", 18'h1, {17'h0, seen_prog});
		dev_model_inst.dev_prog_req = 1'b0;
		watch(4);
	endtask

	// Hardware level 2 first, software level 5 waits for the debreak
	task automatic t_vector;
		dev_model_inst.dev_vec_req = 4'b0100;
		sw_vec_req = 4'b0010;
		watch(5);
		boundary(1'b0);
		watch(4);
		dev_model_inst.dev_vec_req = 4'b0000;
		chk("hw level", 18'h2, {15'h0, lvl});
		chk("hw vector", 18'h0abcd, vec);
		chk("hw grant", 18'h4, {14'h0, grant_or});
		boundary(1'b0);
		watch(4);
		chk("nested hold", 18'h0, {17'h0, seen_vec});
		boundary(1'b1);
		watch(4);
		chk("sw level", 18'h5, {15'h0, lvl});
		chk("sw vector", SW_VECTOR_BASE + 18'h5, vec);
		sw_vec_req = 4'b0000;
		boundary(1'b1);
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial begin
		#(25 * 20000);
		n_fail++;
		test_done;
	end

	initial begin
		rst_b = 1'b0;
		cpu_req = 1'b0;
		cpu_op = 3'h0;
		cpu_dev = 8'h00;
		cpu_ac_out = 18'h0;
		cpu_instr_end = 1'b0;
		prog_int_en = 1'b0;
		cpu_debreak = 1'b0;
		sw_vec_req = 4'h0;
		mem_ack = 1'b0;
		mem_rdata = 18'h0;
		for (int i = 0; i < 256; i++)
			mem[i] = 18'h0;
		repeat (3) @(negedge sys_clk);
		rst_b = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_cmd();
		t_ac();
		t_skip();
		t_block();
		t_arith();
		t_single();
		t_prog();
		t_vector();
		test_done;
	end
endmodule
